// file: core/bgp_top.sv
// GPIO ports A to D with an AXI4-Lite register slave
// Behaviour
// - A, B, D eight pins; C five pins
// - Direction one is output, zero input
// - Direction bit enables the pin driver
// - Reset clears all direction bits
// - Reset leaves data latches untouched
// - Output pins read back the latch
// - Input pins read back the pin level
// - Data writes with the lane 0 strobe set always load the latch
// - Direction registers read back as written; port C keeps only its five low bits
// - B and C pull-ups only on inputs
// - Direct-drive bit selects port C drive
// - Key interrupt pin gets pull-up automatically
// - Key enable makes port D pin interrupt
// - A pull-up only on input pins
`timescale 1ns/10ps
module bgp_top
  import bgp_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // AXI4-Lite write address
  input  wire logic [BGP_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [BGP_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [BGP_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // AXI4-Lite read data
  output logic [BGP_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Port A pins
  input  wire logic [BGP_WIDE_W-1:0]   pa_in,
  output logic      [BGP_WIDE_W-1:0]   pa_out,
  output logic      [BGP_WIDE_W-1:0]   pa_oe,
  output logic      [BGP_WIDE_W-1:0]   pa_pullup,
  // Port B pins
  input  wire logic [BGP_WIDE_W-1:0]   pb_in,
  output logic      [BGP_WIDE_W-1:0]   pb_out,
  output logic      [BGP_WIDE_W-1:0]   pb_oe,
  output logic      [BGP_WIDE_W-1:0]   pb_pullup,
  // Port C pins
  input  wire logic [BGP_NARROW_W-1:0] pc_in,
  output logic      [BGP_NARROW_W-1:0] pc_out,
  output logic      [BGP_NARROW_W-1:0] pc_oe,
  output logic      [BGP_NARROW_W-1:0] pc_pullup,
  output logic                         port_c_direct_drive,
  // Port D pins
  input  wire logic [BGP_WIDE_W-1:0]   pd_in,
  output logic      [BGP_WIDE_W-1:0]   pd_out,
  output logic      [BGP_WIDE_W-1:0]   pd_oe,
  output logic      [BGP_WIDE_W-1:0]   pd_pullup,
  // Keyboard interrupt side of port D
  output logic      [BGP_WIDE_W-1:0]   port_d_key_irq_enables,
  output logic      [BGP_WIDE_W-1:0]   pd_key_level
);

  // Write channel state
  logic                  aw_held;
  logic                  w_held;
  logic [BGP_IDX_W-1:0]  wr_idx;
  logic [7:0]            wr_byte;
  logic                  wr_lane;

  // Bus-side handshakes
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;

  // One write at a time; both halves wait for the response to drain
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Commit once address and data are both held;
  // either half may arrive first and waits here
  wire do_write = aw_held & w_held;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      wr_idx  <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      wr_idx  <= s_axi_awaddr[BGP_ADDR_W-1:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w_held  <= 1'b0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else if (w_take) begin
      w_held  <= 1'b1;
      wr_byte <= s_axi_wdata[7:0];
      wr_lane <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held  <= 1'b0;
    end
  end

  // Write address decode
  wire wr_hit_pa_data = wr_idx == BGP_IDX_PA_DATA;
  wire wr_hit_pb_data = wr_idx == BGP_IDX_PB_DATA;
  wire wr_hit_pc_data = wr_idx == BGP_IDX_PC_DATA;
  wire wr_hit_pd_data = wr_idx == BGP_IDX_PD_DATA;
  wire wr_hit_pa_dir  = wr_idx == BGP_IDX_PA_DIR;
  wire wr_hit_pb_dir  = wr_idx == BGP_IDX_PB_DIR;
  wire wr_hit_pc_dir  = wr_idx == BGP_IDX_PC_DIR;
  wire wr_hit_pd_dir  = wr_idx == BGP_IDX_PD_DIR;
  wire wr_hit_option  = wr_idx == BGP_IDX_OPTION;
  wire wr_hit_key_en  = wr_idx == BGP_IDX_KEY_EN;

  wire wr_mapped = wr_hit_pa_data | wr_hit_pb_data | wr_hit_pc_data |
                   wr_hit_pd_data | wr_hit_pa_dir  | wr_hit_pb_dir  |
                   wr_hit_pc_dir  | wr_hit_pd_dir  | wr_hit_option  |
                   wr_hit_key_en;

  // Lane 0 carries every register; a cleared strobe leaves it alone
  // Upper lanes have no storage, so their strobes are ignored
  wire wr_go = do_write & wr_lane;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= BGP_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? BGP_RESP_OKAY : BGP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Latches have no reset; pins show unknown until first written
  // Port instances
  logic [BGP_WIDE_W-1:0]   pa_dir;
  logic [BGP_WIDE_W-1:0]   pb_dir;
  logic [BGP_NARROW_W-1:0] pc_dir;
  logic [BGP_WIDE_W-1:0]   pd_dir;
  logic [BGP_WIDE_W-1:0]   pa_rd;
  logic [BGP_WIDE_W-1:0]   pb_rd;
  logic [BGP_NARROW_W-1:0] pc_rd;
  logic [BGP_WIDE_W-1:0]   pd_rd;

  bgp_port #(.W(BGP_WIDE_W)) u_port_a (
    .mclk     (mclk),
    .rst      (rst),
    .wr_latch (wr_go & wr_hit_pa_data),
    .wr_dir   (wr_go & wr_hit_pa_dir),
    .wr_data  (wr_byte),
    .pin_in   (pa_in),
    .pin_out  (pa_out),
    .pin_oe   (pa_oe),
    .dir      (pa_dir),
    .rd_data  (pa_rd)
  );

  bgp_port #(.W(BGP_WIDE_W)) u_port_b (
    .mclk     (mclk),
    .rst      (rst),
    .wr_latch (wr_go & wr_hit_pb_data),
    .wr_dir   (wr_go & wr_hit_pb_dir),
    .wr_data  (wr_byte),
    .pin_in   (pb_in),
    .pin_out  (pb_out),
    .pin_oe   (pb_oe),
    .dir      (pb_dir),
    .rd_data  (pb_rd)
  );

  bgp_port #(.W(BGP_NARROW_W)) u_port_c (
    .mclk     (mclk),
    .rst      (rst),
    .wr_latch (wr_go & wr_hit_pc_data),
    .wr_dir   (wr_go & wr_hit_pc_dir),
    .wr_data  (wr_byte[BGP_NARROW_W-1:0]),
    .pin_in   (pc_in),
    .pin_out  (pc_out),
    .pin_oe   (pc_oe),
    .dir      (pc_dir),
    .rd_data  (pc_rd)
  );

  bgp_port #(.W(BGP_WIDE_W)) u_port_d (
    .mclk     (mclk),
    .rst      (rst),
    .wr_latch (wr_go & wr_hit_pd_data),
    .wr_dir   (wr_go & wr_hit_pd_dir),
    .wr_data  (wr_byte),
    .pin_in   (pd_in),
    .pin_out  (pd_out),
    .pin_oe   (pd_oe),
    .dir      (pd_dir),
    .rd_data  (pd_rd)
  );

  // Option and key enable registers
  logic [7:0] option;
  logic [7:0] key_en;

  bgp_optreg #(.MASK(BGP_OPT_MASK), .RESET(BGP_OPT_RESET)) u_option (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (wr_go & wr_hit_option),
    .wr_data (wr_byte),
    .value   (option)
  );

  bgp_optreg #(.MASK(BGP_KEY_MASK), .RESET(BGP_KEY_RESET)) u_key_en (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (wr_go & wr_hit_key_en),
    .wr_data (wr_byte),
    .value   (key_en)
  );

  // Pull-ups never fight an enabled driver
  // Port D is left out: its pull-ups follow the key enables
  assign pa_pullup = {BGP_WIDE_W{option[BGP_OPT_PA_PULLUP]}} &
                     ~pa_dir;
  assign pb_pullup = {BGP_WIDE_W{option[BGP_OPT_PB_PULLUP]}} &
                     ~pb_dir;
  assign pc_pullup = {BGP_NARROW_W{option[BGP_OPT_PC_PULLUP]}} &
                     ~pc_dir;
  assign port_c_direct_drive = option[BGP_OPT_PC_DIRECT];

  // Key interrupt pins pull up on their own
  assign pd_pullup = key_en;
  // Only enabled pins reach the keyboard logic
  assign port_d_key_irq_enables = key_en;
  assign pd_key_level           = pd_in & key_en;

  // Read decode; pins sampled when the address is taken
  // A pin moving in that same cycle may read either level
  wire [BGP_IDX_W-1:0] rd_idx = s_axi_araddr[BGP_ADDR_W-1:2];

  wire rd_hit_pa_data = rd_idx == BGP_IDX_PA_DATA;
  wire rd_hit_pb_data = rd_idx == BGP_IDX_PB_DATA;
  wire rd_hit_pc_data = rd_idx == BGP_IDX_PC_DATA;
  wire rd_hit_pd_data = rd_idx == BGP_IDX_PD_DATA;
  wire rd_hit_pa_dir  = rd_idx == BGP_IDX_PA_DIR;
  wire rd_hit_pb_dir  = rd_idx == BGP_IDX_PB_DIR;
  wire rd_hit_pc_dir  = rd_idx == BGP_IDX_PC_DIR;
  wire rd_hit_pd_dir  = rd_idx == BGP_IDX_PD_DIR;
  wire rd_hit_option  = rd_idx == BGP_IDX_OPTION;
  wire rd_hit_key_en  = rd_idx == BGP_IDX_KEY_EN;

  wire rd_mapped = rd_hit_pa_data | rd_hit_pb_data | rd_hit_pc_data |
                   rd_hit_pd_data | rd_hit_pa_dir  | rd_hit_pb_dir  |
                   rd_hit_pc_dir  | rd_hit_pd_dir  | rd_hit_option  |
                   rd_hit_key_en;

  // Port C upper bits read as zero
  wire [7:0] pc_rd_byte  = {3'h0, pc_rd};
  wire [7:0] pc_dir_byte = {3'h0, pc_dir};

  // At most one index hits, so the chain order does not matter
  wire [7:0] rd_byte =
    rd_hit_pa_data ? pa_rd       :
    rd_hit_pb_data ? pb_rd       :
    rd_hit_pc_data ? pc_rd_byte  :
    rd_hit_pd_data ? pd_rd       :
    rd_hit_pa_dir  ? pa_dir      :
    rd_hit_pb_dir  ? pb_dir      :
    rd_hit_pc_dir  ? pc_dir_byte :
    rd_hit_pd_dir  ? pd_dir      :
    rd_hit_option  ? option      :
    rd_hit_key_en  ? key_en      : 8'h00;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= BGP_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_mapped ? BGP_RESP_OKAY : BGP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: core/bgp_pkg.sv
// Register map, field layout and reset values of the GPIO ports block
package bgp_pkg;

  // Bus geometry
  localparam int          BGP_ADDR_W     = 8;
  localparam int          BGP_DATA_W     = 32;
  localparam int          BGP_IDX_W      = 6;

  // Port widths
  localparam int          BGP_WIDE_W     = 8;
  localparam int          BGP_NARROW_W   = 5;

  // Register indices; byte address is four times the index
  localparam logic [5:0]  BGP_IDX_PA_DATA = 6'h00;
  localparam logic [5:0]  BGP_IDX_PB_DATA = 6'h01;
  localparam logic [5:0]  BGP_IDX_PC_DATA = 6'h02;
  localparam logic [5:0]  BGP_IDX_PD_DATA = 6'h03;
  localparam logic [5:0]  BGP_IDX_PA_DIR  = 6'h04;
  localparam logic [5:0]  BGP_IDX_PB_DIR  = 6'h05;
  localparam logic [5:0]  BGP_IDX_PC_DIR  = 6'h06;
  localparam logic [5:0]  BGP_IDX_PD_DIR  = 6'h07;
  localparam logic [5:0]  BGP_IDX_OPTION  = 6'h1D;
  localparam logic [5:0]  BGP_IDX_KEY_EN  = 6'h1E;

  // Port option control fields
  localparam int          BGP_OPT_PA_PULLUP   = 0;
  localparam int          BGP_OPT_PB_PULLUP   = 1;
  localparam int          BGP_OPT_PC_PULLUP   = 2;
  localparam int          BGP_OPT_PC_DIRECT   = 5;
  localparam logic [7:0]  BGP_OPT_MASK        = 8'h27;
  localparam logic [7:0]  BGP_OPT_RESET       = 8'h20;

  // Key interrupt enable register
  localparam logic [7:0]  BGP_KEY_MASK        = 8'hFF;
  localparam logic [7:0]  BGP_KEY_RESET       = 8'h00;

  // Direction reset value
  localparam logic [7:0]  BGP_DIR_RESET       = 8'h00;

  // Bus responses
  localparam logic [1:0]  BGP_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  BGP_RESP_SLVERR     = 2'h2;

endpackage

// file: core/bgp_port.sv
// One bidirectional port: data latch, direction bits and read mux
`timescale 1ns/10ps
module bgp_port
  import bgp_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Register writes
  input  wire logic         wr_latch,
  input  wire logic         wr_dir,
  input  wire logic [W-1:0] wr_data,
  // Pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  // Register readback
  output logic      [W-1:0] dir,
  output logic      [W-1:0] rd_data
);

  logic [W-1:0] latch;

  // No reset: latch keeps its value across reset
  always_ff @(posedge mclk) begin
    if (wr_latch) begin
      latch <= wr_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dir <= BGP_DIR_RESET[W-1:0];
    end else if (wr_dir) begin
      dir <= wr_data;
    end
  end

  // Driver follows direction bits
  assign pin_out = latch;
  assign pin_oe  = dir;

  // Outputs read latch, inputs read the pin
  assign rd_data = (dir & latch) | (~dir & pin_in);

endmodule

// file: core/bgp_optreg.sv
// Small software register with masked bits and a reset value
`timescale 1ns/10ps
module bgp_optreg
  import bgp_pkg::*;
#(
  parameter logic [7:0] MASK  = 8'hFF,
  parameter logic [7:0] RESET = 8'h00
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value
  output logic      [7:0] value
);

  // Unimplemented bits never store, so they read zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      value <= RESET & MASK;
    end else if (wr_en) begin
      value <= wr_data & MASK;
    end
  end

endmodule

// file: verification/bgp_monitor.sv
// Bus timing and pin relation checks for the GPIO ports block
`timescale 1ns/10ps
module bgp_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins
  input wire logic [7:0]  pa_oe,
  input wire logic [7:0]  pb_oe,
  input wire logic [4:0]  pc_oe,
  input wire logic [7:0]  pd_oe,
  input wire logic [7:0]  pa_pullup,
  input wire logic [7:0]  pb_pullup,
  input wire logic [4:0]  pc_pullup,
  input wire logic [7:0]  pd_pullup,
  input wire logic [7:0]  pd_in,
  input wire logic [7:0]  port_d_key_irq_enables,
  input wire logic [7:0]  pd_key_level
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_dir_cleared: assert property (
    $fell(rst) |-> {pa_oe, pb_oe, pc_oe, pd_oe} == 29'h0)
    else $error("Drivers on after reset");
  chk_pullup_gate: assert property (
    (pa_pullup & pa_oe) == 8'h0 && (pb_pullup & pb_oe) == 8'h0
    && (pc_pullup & pc_oe) == 5'h0)
    else $error("Pull-up on an output pin");
  chk_key_pullup: assert property (
    pd_pullup == port_d_key_irq_enables)
    else $error("Key pin pull-up mismatch");
  chk_key_level: assert property (
    pd_key_level == (pd_in & port_d_key_irq_enables))
    else $error("Key level mismatch");
  // Only a committed write may move a driver enable
  chk_dir_commit: assert property (
    !$stable({pa_oe, pb_oe, pc_oe, pd_oe}) |-> $rose(s_axi_bvalid))
    else $error("Direction moved without a write");
  chk_write_lat: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("Write response late");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped");
  chk_ar_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while busy");

  cov_write: cover property (s_axi_awvalid && s_axi_awready);
  cov_read: cover property (s_axi_arvalid && s_axi_arready);
  cov_key: cover property (port_d_key_irq_enables != 8'h0);
endmodule

// file: verification/bgp_board.sv
// Board model: resolves each pin from the driver and a board source
`timescale 1ns/10ps
module bgp_board #(
  parameter int W = 8
) (
  // Device side
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  // Board side
  input  wire logic [W-1:0] drv,
  output logic      [W-1:0] level
);
  // Enabled driver wins, board source otherwise
  assign level = (oe & out) | (~oe & drv);
endmodule

// file: verification/bgp_top_test.sv
// Register bus test of the GPIO ports block
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: %h %h", $time, g, e); end end
module bgp_top_test
  import bgp_pkg::*;
;
  logic        mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, port_c_direct_drive;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, drv, m;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pa_in, pa_out, pa_oe, pa_pullup, pb_in, pb_out, pb_oe, pb_pullup;
  logic [7:0]  pd_in, pd_out, pd_oe, pd_pullup, pd_key_level;
  logic [7:0]  port_d_key_irq_enables;
  logic [4:0]  pc_in, pc_out, pc_oe, pc_pullup;
  int          bad_count, cmp_count, p;

  bgp_top i_bgp_top (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pa_in, .pa_out, .pa_oe, .pa_pullup, .pb_in, .pb_out, .pb_oe, .pb_pullup,
    .pc_in, .pc_out, .pc_oe, .pc_pullup, .port_c_direct_drive, .pd_in,
    .pd_out, .pd_oe, .pd_pullup, .port_d_key_irq_enables, .pd_key_level);
  bgp_board #(.W(8)) i_bgp_board_a (.out(pa_out), .oe(pa_oe), .drv(drv),
    .level(pa_in));
  bgp_board #(.W(8)) i_bgp_board_b (.out(pb_out), .oe(pb_oe), .drv(drv),
    .level(pb_in));
  bgp_board #(.W(5)) i_bgp_board_c (.out(pc_out), .oe(pc_oe),
    .drv(drv[4:0]), .level(pc_in));
  bgp_board #(.W(8)) i_bgp_board_d (.out(pd_out), .oe(pd_oe), .drv(drv),
    .level(pd_in));

  function automatic logic [7:0] ba(input int i);
    return 8'(i * 4);
  endfunction

  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One bus transfer; d is write data or expected read data
  task automatic xfer(input int wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] r);
    int n;
    logic w, ha, hw, hr, hb, hv;
    logic [31:0] rd;
    logic [1:0] rs;
    w = (wr != 0);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    for (n = 0; n < 40; n++) begin
      // Readies are settled at the falling edge
      @(negedge mclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      hr = s_axi_arready;
      hv = s_axi_rvalid;
      hb = w ? s_axi_bvalid : (s_axi_rvalid & s_axi_rready);
      rd = s_axi_rdata;
      rs = w ? s_axi_bresp : s_axi_rresp;
      @(posedge mclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hr) s_axi_arvalid <= 1'b0;
      if (hb) break;
      // Late rready stalls read data one cycle, like a slow master
      if (hv) s_axi_rready <= !w;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      bad_count++;
      tally_and_finish();
    end
    `CHK(rs, r)
    if (!w) `CHK(rd, d)
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    drv = 8'h5A;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (p = 4; p < 8; p++) xfer(0, ba(p), 0, BGP_RESP_OKAY);
    xfer(0, ba(BGP_IDX_OPTION), 32'h20, BGP_RESP_OKAY);
    for (p = 0; p < 4; p++) begin
      m = (p == 2) ? 8'h1F : 8'hFF;
      xfer(1, ba(p), 32'hC3, BGP_RESP_OKAY);
      xfer(1, ba(p + 4), 32'h0F, BGP_RESP_OKAY);
      xfer(0, ba(p + 4), {24'h0, 8'h0F & m}, BGP_RESP_OKAY);
      xfer(0, ba(p), {24'h0, 8'h53 & m}, BGP_RESP_OKAY);
    end
    `CHK(pa_out, 8'hC3)
    `CHK(pa_oe, 8'h0F)
    `CHK(pc_oe, 5'h0F)
    xfer(1, ba(BGP_IDX_PC_DIR), 32'hFF, BGP_RESP_OKAY);
    xfer(0, ba(BGP_IDX_PC_DIR), 32'h1F, BGP_RESP_OKAY);
    xfer(0, ba(BGP_IDX_PC_DATA), 32'h03, BGP_RESP_OKAY);
    xfer(1, ba(BGP_IDX_PA_DIR), 32'h0, BGP_RESP_OKAY);
    xfer(1, ba(BGP_IDX_PA_DATA), 32'h99, BGP_RESP_OKAY);
    drv <= 8'h3C;
    xfer(0, ba(BGP_IDX_PA_DATA), 32'h3C, BGP_RESP_OKAY);
    `CHK(pa_out, 8'h99)
    xfer(1, ba(BGP_IDX_OPTION), 32'h27, BGP_RESP_OKAY);
    `CHK(pa_pullup, 8'hFF)
    `CHK(pb_pullup, 8'hF0)
    `CHK(pc_pullup, 5'h00)
    `CHK(port_c_direct_drive, 1'b1)
    xfer(1, ba(BGP_IDX_OPTION), 32'h07, BGP_RESP_OKAY);
    `CHK(port_c_direct_drive, 1'b0)
    xfer(1, ba(BGP_IDX_KEY_EN), 32'hA5, BGP_RESP_OKAY);
    `CHK(pd_pullup, 8'hA5)
    `CHK(port_d_key_irq_enables, 8'hA5)
    `CHK(pd_key_level, 8'h21)
    s_axi_wstrb <= 4'hE;
    xfer(1, ba(BGP_IDX_PA_DATA), 32'h11, BGP_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    `CHK(pa_out, 8'h99)
    xfer(1, 8'h80, 32'h1, BGP_RESP_SLVERR);
    xfer(0, 8'h80, 32'h0, BGP_RESP_SLVERR);
    // Second reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK(pa_out, 8'h99)
    `CHK(pd_out, 8'hC3)
    `CHK(pb_oe, 8'h00)
    xfer(0, ba(BGP_IDX_OPTION), 32'h20, BGP_RESP_OKAY);
    tally_and_finish();
  end
endmodule

bind bgp_top bgp_monitor i_bgp_monitor (.mclk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pa_oe, .pb_oe,
  .pc_oe, .pd_oe, .pa_pullup, .pb_pullup, .pc_pullup, .pd_pullup, .pd_in,
  .port_d_key_irq_enables, .pd_key_level);
